// [src/byte_lane_endian_adapter.sv]
// lane placement and byte order correction between a big-endian
// byte-invariant master and a little-endian lane interconnect
// assumes one outstanding read at a time and aligned requests
//
// Functional notes
// - byte writes enable and fill only the lane of their offset
// - halfword enables 0011 or 1100, word 1111; top byte lowest lane
// - slave lanes ascend, byte offset zero on data bits 7:0
// - a 16-bit value with foreign ordering has its two bytes exchanged
// - packed pair of 16-bit values swaps each half on its own
// - a 32-bit value with foreign ordering has all four bytes reversed
// - same ordering on both ends passes data without any exchange
// - 16-bit reads from little-endian slaves are corrected before use
// - reordering width follows the value, neighbours stay untouched
`timescale 1ns/100ps
`default_nettype none

module byte_lane_endian_adapter
   import endian_adapter_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic CE_I,
   input wire cmd_s M_CMD_I,
   input wire logic [WORD_W-1:0] S_RDATA_I,
   input wire logic S_RVALID_I,
   output logic S_REQ_O,
   output logic S_WRITE_O,
   output logic [WORD_BYTES-1:0] S_BYTEEN_O,
   output logic [WORD_W-1:0] S_WDATA_O,
   output logic [WORD_W-1:0] M_RDATA_O,
   output logic M_RVALID_O
);

   logic s_req_q, s_req_d;
   logic s_write_q, s_write_d;
   logic [WORD_BYTES-1:0] s_be_q, s_be_d;
   logic [WORD_W-1:0] s_wdata_q, s_wdata_d;
   logic [WORD_W-1:0] m_rdata_q, m_rdata_d;
   logic m_rvalid_q, m_rvalid_d;
   size_e rd_size_q, rd_size_d;
   logic [OFF_W-1:0] rd_off_q, rd_off_d;
   swap_e rd_mode_q, rd_mode_d;

   logic [WORD_W-1:0] wr_value;
   logic [WORD_W-1:0] rd_raw;
   logic [WORD_W-1:0] rd_value;
   logic [OFF_W-1:0] wr_base;
   logic [OFF_W-1:0] rd_base;

   // write value is reordered first, then placed on the lanes
   byte_order_swap u_wr_swap (
      .size_i(M_CMD_I.size),
      .mode_i(M_CMD_I.mode),
      .data_i(M_CMD_I.wdata),
      .data_o(wr_value)
   );

   // read value is gathered from the lanes, then reordered
   byte_order_swap u_rd_swap (
      .size_i(rd_size_q),
      .mode_i(rd_mode_q),
      .data_i(rd_raw),
      .data_o(rd_value)
   );

   // request path: lane placement and byte enables
   always_comb begin
      s_req_d = M_CMD_I.req;
      s_write_d = M_CMD_I.write;
      s_be_d = BE_NONE;
      s_wdata_d = WORD_ZERO;
      wr_base = M_CMD_I.offset & ~HALF_STEP;
      if (M_CMD_I.req) begin
         unique case (M_CMD_I.size)
            SIZE_8: begin
               s_be_d = BE_ONE << M_CMD_I.offset;
               s_wdata_d[M_CMD_I.offset*BYTE_W +: BYTE_W] =
                  wr_value[BYTE_W-1:0];
            end
            SIZE_16: begin
               // most significant byte on the lower lane
               s_be_d = BE_TWO << wr_base;
               s_wdata_d[wr_base*BYTE_W +: BYTE_W] =
                  wr_value[BYTE_W +: BYTE_W];
               s_wdata_d[(wr_base+HALF_STEP)*BYTE_W +: BYTE_W] =
                  wr_value[BYTE_W-1:0];
            end
            default: begin
               s_be_d = BE_ALL;
               for (int k = 0; k < WORD_BYTES; k++) begin
                  s_wdata_d[k*BYTE_W +: BYTE_W] =
                     wr_value[(LAST_BYTE-k)*BYTE_W +: BYTE_W];
               end
            end
         endcase
         if (!M_CMD_I.write) begin
            s_wdata_d = WORD_ZERO;
         end
      end
   end

   // attributes of the pending read, kept until its data returns
   always_comb begin
      rd_size_d = rd_size_q;
      rd_off_d = rd_off_q;
      rd_mode_d = rd_mode_q;
      if (M_CMD_I.req && !M_CMD_I.write) begin
         rd_size_d = M_CMD_I.size;
         rd_off_d = M_CMD_I.offset;
         rd_mode_d = M_CMD_I.mode;
      end
   end

   // gather read bytes; lane k holds byte offset k
   always_comb begin
      rd_raw = WORD_ZERO;
      rd_base = rd_off_q & ~HALF_STEP;
      unique case (rd_size_q)
         SIZE_8: begin
            rd_raw[BYTE_W-1:0] =
               S_RDATA_I[rd_off_q*BYTE_W +: BYTE_W];
         end
         SIZE_16: begin
            rd_raw[BYTE_W +: BYTE_W] =
               S_RDATA_I[rd_base*BYTE_W +: BYTE_W];
            rd_raw[BYTE_W-1:0] =
               S_RDATA_I[(rd_base+HALF_STEP)*BYTE_W +: BYTE_W];
         end
         default: begin
            for (int k = 0; k < WORD_BYTES; k++) begin
               rd_raw[(LAST_BYTE-k)*BYTE_W +: BYTE_W] =
                  S_RDATA_I[k*BYTE_W +: BYTE_W];
            end
         end
      endcase
   end

   always_comb begin
      m_rvalid_d = S_RVALID_I;
      m_rdata_d = m_rdata_q;
      if (S_RVALID_I) begin
         m_rdata_d = rd_value;
      end
   end

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         s_req_q <= 1'b0;
         s_write_q <= 1'b0;
         s_be_q <= BE_NONE;
         s_wdata_q <= WORD_ZERO;
         m_rdata_q <= WORD_ZERO;
         m_rvalid_q <= 1'b0;
         rd_size_q <= SIZE_8;
         rd_off_q <= OFF_ZERO;
         rd_mode_q <= SWAP_PASS;
      end else if (CE_I) begin
         s_req_q <= s_req_d;
         s_write_q <= s_write_d;
         s_be_q <= s_be_d;
         s_wdata_q <= s_wdata_d;
         m_rdata_q <= m_rdata_d;
         m_rvalid_q <= m_rvalid_d;
         rd_size_q <= rd_size_d;
         rd_off_q <= rd_off_d;
         rd_mode_q <= rd_mode_d;
      end
   end

   assign S_REQ_O = s_req_q;
   assign S_WRITE_O = s_write_q;
   assign S_BYTEEN_O = s_be_q;
   assign S_WDATA_O = s_wdata_q;
   assign M_RDATA_O = m_rdata_q;
   assign M_RVALID_O = m_rvalid_q;

   // checks of the lane and byte order behaviour
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RESET_I);

   logic wr_go;
   assign wr_go = CE_I && M_CMD_I.req && M_CMD_I.write;

   a_byte_enable_one: assert property (
      wr_go && M_CMD_I.size == SIZE_8
      |=> S_BYTEEN_O == (BE_ONE << $past(M_CMD_I.offset)))
      else $error("byte write enable not on its offset lane");

   a_byte_lane_data: assert property (
      wr_go && M_CMD_I.size == SIZE_8
      |=> ((S_WDATA_O >> ($past(M_CMD_I.offset)*BYTE_W))
           & WORD_W'(BYTE_ONES)) == WORD_W'($past(M_CMD_I.wdata[BYTE_W-1:0])))
      else $error("byte write data not on its offset lane");

   a_half_enable: assert property (
      wr_go && M_CMD_I.size == SIZE_16
      |=> S_BYTEEN_O == ($past(M_CMD_I.offset[1]) ? BE_HIGH_HALF : BE_TWO))
      else $error("halfword write enables wrong");

   a_word_msb_low: assert property (
      wr_go && M_CMD_I.size == SIZE_32 && M_CMD_I.mode == SWAP_PASS
      |=> S_BYTEEN_O == BE_ALL && S_WDATA_O[BYTE_W-1:0] ==
          $past(M_CMD_I.wdata[WORD_W-1 -: BYTE_W]))
      else $error("word most significant byte not on lane zero");

   a_pass_half: assert property (
      wr_go && M_CMD_I.size == SIZE_16 && M_CMD_I.mode == SWAP_PASS &&
      M_CMD_I.offset == OFF_ZERO
      |=> S_WDATA_O[HALF_W-1:0] == {$past(M_CMD_I.wdata[BYTE_W-1:0]),
          $past(M_CMD_I.wdata[BYTE_W +: BYTE_W])})
      else $error("pass mode altered halfword order");

   a_swap_half: assert property (
      wr_go && M_CMD_I.size == SIZE_16 && M_CMD_I.mode == SWAP_16 &&
      M_CMD_I.offset == OFF_ZERO
      |=> S_WDATA_O[HALF_W-1:0] == $past(M_CMD_I.wdata[HALF_W-1:0]))
      else $error("halfword swap not applied");

   a_pair_swap: assert property (
      wr_go && M_CMD_I.size == SIZE_32 && M_CMD_I.mode == SWAP_PAIR16
      |=> S_WDATA_O == {$past(M_CMD_I.wdata[HALF_W-1:0]),
          $past(M_CMD_I.wdata[WORD_W-1:HALF_W])})
      else $error("paired halfword swap wrong");

   a_full_reverse: assert property (
      wr_go && M_CMD_I.size == SIZE_32 && M_CMD_I.mode == SWAP_32
      |=> S_WDATA_O == $past(M_CMD_I.wdata))
      else $error("full word reversal wrong");

   a_lanes_bounded: assert property (
      wr_go && M_CMD_I.size != SIZE_32
      |=> (S_WDATA_O & ~lane_mask(S_BYTEEN_O)) == WORD_ZERO)
      else $error("data outside the enabled lanes");

   a_read_half_fix: assert property (
      CE_I && S_RVALID_I && rd_size_q == SIZE_16 &&
      rd_mode_q == SWAP_16 && rd_off_q == OFF_ZERO
      |=> M_RVALID_O && M_RDATA_O == {HALF_ZERO,
          $past(S_RDATA_I[HALF_W-1:0])})
      else $error("halfword read not corrected");

   a_read_byte_lane: assert property (
      CE_I && S_RVALID_I && rd_size_q == SIZE_8
      |=> M_RDATA_O == ($past(S_RDATA_I) >> ($past(rd_off_q)*BYTE_W)
          & WORD_W'(BYTE_ONES)))
      else $error("byte read taken from wrong lane");

   a_request_follows: assert property (
      CE_I |=> S_REQ_O == $past(M_CMD_I.req) &&
      S_WRITE_O == $past(M_CMD_I.write))
      else $error("request not forwarded next cycle");

   c_byte_write: cover property (wr_go && M_CMD_I.size == SIZE_8);
   c_pair_write: cover property (
      wr_go && M_CMD_I.size == SIZE_32 && M_CMD_I.mode == SWAP_PAIR16);
   c_reverse_write: cover property (
      wr_go && M_CMD_I.size == SIZE_32 && M_CMD_I.mode == SWAP_32);
   c_half_read: cover property (
      CE_I && S_RVALID_I && rd_size_q == SIZE_16 && rd_mode_q == SWAP_16);

endmodule

`default_nettype wire

// [src/byte_order_swap.sv]
// byte reordering of one right-justified arithmetic value
// assumes size and mode are stable while the result is used
`timescale 1ns/100ps
`default_nettype none

module byte_order_swap
   import endian_adapter_pkg::*;
(
   input wire size_e size_i,
   input wire swap_e mode_i,
   input wire logic [WORD_W-1:0] data_i,
   output logic [WORD_W-1:0] data_o
);

   logic [OFF_W-1:0] src;

   always_comb begin
      data_o = WORD_ZERO;
      src = OFF_ZERO;
      for (int k = 0; k < WORD_BYTES; k++) begin
         src = OFF_W'(k);
         if (size_i != SIZE_8) begin
            unique case (mode_i)
               SWAP_PASS: begin
                  src = OFF_W'(k);
               end
               SWAP_16, SWAP_PAIR16: begin
                  src = OFF_W'(k) ^ HALF_STEP;
               end
               SWAP_32: begin
                  // a 16-bit value only ever swaps within itself
                  if (size_i == SIZE_16) begin
                     src = OFF_W'(k) ^ HALF_STEP;
                  end else begin
                     src = OFF_W'(LAST_BYTE - k);
                  end
               end
            endcase
         end
         data_o[k*BYTE_W +: BYTE_W] = data_i[src*BYTE_W +: BYTE_W];
      end
   end

endmodule

`default_nettype wire

// [src/endian_adapter_pkg.sv]
// shared types and constants of the byte lane and byte order adapter
// assumes a 32-bit little-endian lane interconnect on the slave side
package endian_adapter_pkg;

   localparam int BYTE_W = 8;
   localparam int WORD_BYTES = 4;
   localparam int WORD_W = BYTE_W * WORD_BYTES;
   localparam int HALF_W = WORD_W / 2;
   localparam int OFF_W = 2;
   localparam int LAST_BYTE = WORD_BYTES - 1;

   localparam logic [WORD_BYTES-1:0] BE_NONE = 4'h0;
   localparam logic [WORD_BYTES-1:0] BE_ONE = 4'h1;
   localparam logic [WORD_BYTES-1:0] BE_TWO = 4'h3;
   localparam logic [WORD_BYTES-1:0] BE_HIGH_HALF = 4'hc;
   localparam logic [WORD_BYTES-1:0] BE_ALL = 4'hf;
   localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0;
   localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0;
   localparam logic [BYTE_W-1:0] BYTE_ONES = 8'hff;
   localparam logic [OFF_W-1:0] OFF_ZERO = 2'h0;
   localparam logic [OFF_W-1:0] HALF_STEP = 2'h1;

   typedef enum logic [1:0] {
      SIZE_8 = 2'b00,
      SIZE_16 = 2'b01,
      SIZE_32 = 2'b10
   } size_e;

   typedef enum logic [1:0] {
      SWAP_PASS = 2'b00,
      SWAP_16 = 2'b01,
      SWAP_32 = 2'b10,
      SWAP_PAIR16 = 2'b11
   } swap_e;

   typedef struct packed {
      logic req;
      logic write;
      size_e size;
      logic [OFF_W-1:0] offset;
      swap_e mode;
      logic [WORD_W-1:0] wdata;
   } cmd_s;

   // expands byte enables to a bit mask over the data lanes
   function automatic logic [WORD_W-1:0] lane_mask(
      input logic [WORD_BYTES-1:0] be
   );
      logic [WORD_W-1:0] m;
      m = WORD_ZERO;
      for (int k = 0; k < WORD_BYTES; k++) begin
         if (be[k]) begin
            m[k*BYTE_W +: BYTE_W] = BYTE_ONES;
         end
      end
      return m;
   endfunction

endpackage

// [verification/le_slave_model.sv]
// single-word little-endian slave on the lane side of the adapter
// assumes one read outstanding; answers after one or three cycles
`timescale 1ns/100ps
`default_nettype none

module le_slave_model
   import endian_adapter_pkg::*;
(
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic write_i,
   input wire logic [WORD_BYTES-1:0] be_i,
   input wire logic [WORD_W-1:0] wdata_i,
   input wire logic slow_i,
   output logic [WORD_W-1:0] rdata_o,
   output logic rvalid_o
);
   logic [WORD_W-1:0] mem = WORD_ZERO;
   int wait_n = 0;

   initial begin
      rdata_o = WORD_ZERO;
      rvalid_o = 1'h0;
   end

   // idle read data toggles so stale bytes never look valid
   always @(posedge clk_i) begin
      rvalid_o <= 1'h0;
      rdata_o <= ~rdata_o;
      for (int k = 0; k < WORD_BYTES; k++) begin
         if (req_i && write_i && be_i[k]) begin
            mem[k*BYTE_W +: BYTE_W] <= wdata_i[k*BYTE_W +: BYTE_W];
         end
      end
      if (wait_n > 0) begin
         wait_n <= wait_n - 1;
      end
      if (req_i && !write_i) begin
         wait_n <= slow_i ? 3 : 1;
      end
      if (wait_n == 1) begin
         rvalid_o <= 1'h1;
         rdata_o <= mem;
      end
   end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench of the byte lane and byte order adapter
// assumes the single-word slave model on the lane side
`timescale 1ns/100ps
`default_nettype none

module tb_top
   import endian_adapter_pkg::*;
;
   logic clk = 1'h0;
   logic rst, ce, slow, ce_seen = 1'h0;
   cmd_s cmd;
   logic [WORD_W-1:0] s_rdata, s_wdata, m_rdata, mem = 32'h0, v, lo, hi;
   logic s_rvalid, s_req, s_write, m_rvalid;
   logic [WORD_BYTES-1:0] s_be;
   logic [36:0] wq[$];
   logic [WORD_W-1:0] rq[$];
   int n_fail = 0, checked = 0, cyc = 0;

   byte_lane_endian_adapter uut (.CLK_I(clk), .RESET_I(rst), .CE_I(ce),
      .M_CMD_I(cmd), .S_RDATA_I(s_rdata), .S_RVALID_I(s_rvalid),
      .S_REQ_O(s_req), .S_WRITE_O(s_write), .S_BYTEEN_O(s_be),
      .S_WDATA_O(s_wdata), .M_RDATA_O(m_rdata), .M_RVALID_O(m_rvalid));
   le_slave_model slave (.clk_i(clk), .req_i(s_req), .write_i(s_write),
      .be_i(s_be), .wdata_i(s_wdata), .slow_i(slow), .rdata_o(s_rdata),
      .rvalid_o(s_rvalid));

   initial begin
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] rv(input logic [31:0] w);
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

   function automatic logic [31:0] sw(input swap_e md, input logic [31:0] w);
      if (md == SWAP_32) return rv(w);
      if (md == SWAP_PASS) return w;
      return {w[23:16], w[31:24], w[7:0], w[15:8]};
   endfunction

   // expected {write, enables, lane data} of one access
   function automatic logic [36:0] put(input logic wr, input size_e sz,
      input logic [1:0] off, input swap_e md, input logic [31:0] v);
      logic [15:0] h;
      int b;
      h = (md == SWAP_PASS) ? v[15:0] : {v[7:0], v[15:8]};
      b = 8 * {off[1], 1'h0};
      if (sz == SIZE_8) return {wr, 4'h1 << off, {24'h0, v[7:0]} << (8 * off)};
      if (sz == SIZE_16) return {wr, 4'h3 << (b / 8), {16'h0, h[7:0], h[15:8]} << b};
      return {wr, 4'hf, rv(sw(md, v))};
   endfunction

   // expected right-justified read value gathered from slave word r
   function automatic logic [31:0] get(input size_e sz, input logic [1:0] off,
      input swap_e md, input logic [31:0] r);
      logic [31:0] t;
      logic [15:0] h;
      t = r >> (8 * {off[1], 1'h0});
      h = {t[7:0], t[15:8]};
      if (md != SWAP_PASS) h = {h[7:0], h[15:8]};
      if (sz == SIZE_8) return (r >> (8 * off)) & 32'hff;
      if (sz == SIZE_16) return {16'h0, h};
      return sw(md, rv(r));
   endfunction

   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      // expectations never matched by a response count as lost transfers
      n_fail += wq.size() + rq.size();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic access(input logic wr, input size_e sz, input logic [1:0] off,
      input swap_e md, input logic [31:0] d);
      logic [36:0] e;
      e = put(wr, sz, off, md, wr ? d : 32'h0);
      wq.push_back(e);
      if (!wr) rq.push_back(get(sz, off, md, mem));
      for (int k = 0; k < 4; k++) begin
         if (wr && e[32+k]) mem[8*k +: 8] = e[8*k +: 8];
      end
      cmd <= {1'h1, wr, sz, off, md, d};
      @(negedge clk);
   endtask

   task automatic rd(input size_e sz, input logic [1:0] off, input swap_e md,
      output logic [31:0] r);
      access(1'h0, sz, off, md, 32'h0);
      cmd.req <= 1'h0;
      @(negedge clk);
      for (int i = 0; i < 10 && m_rvalid !== 1'h1; i++) @(negedge clk);
      r = m_rdata;
   endtask

   always @(posedge clk) begin
      ce_seen <= ce;
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         final_report();
      end
   end

   always @(negedge clk) begin
      if (rst === 1'h0 && ce_seen && s_req === 1'h1) begin
         check({3'h0, s_write, s_be, s_wdata}, {3'h0, wq.pop_front()});
      end
      if (rst === 1'h0 && ce_seen && m_rvalid === 1'h1) begin
         check({8'h0, m_rdata}, {8'h0, rq.pop_front()});
      end
   end

   initial begin
      rst = 1'h1;
      ce = 1'h1;
      slow = 1'h0;
      cmd = '0;
      void'($urandom(39));
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst <= 1'h0;
      @(negedge clk);
      for (int s = 0; s < 3; s++) begin
         for (int o = 0; o < 4; o++) begin
            for (int m = 0; m < 4; m++) begin
               slow <= 1'($urandom_range(1, 0));
               v = (s == 0) ? o : (s == 1) ? (o & 2) : 0;
               access(1'h1, size_e'(s), v[1:0], swap_e'(m), $urandom);
               rd(size_e'(s), v[1:0], swap_e'(m), lo);
            end
         end
      end
      $display("test size mode table done");
      repeat (8) begin
         // size code 3 and misaligned offsets are exercised here too
         access(1'h1, size_e'($urandom_range(3, 0)),
            2'($urandom_range(3, 0)), swap_e'($urandom_range(3, 0)),
            $urandom);
      end
      cmd.req <= 1'h0;
      @(negedge clk);
      $display("test back to back writes done");
      access(1'h1, SIZE_32, 2'h0, SWAP_PASS, 32'h00080000);
      rd(SIZE_16, 2'h0, SWAP_PASS, lo);
      check({8'h0, lo}, 40'h0008);
      rd(SIZE_16, 2'h0, SWAP_16, lo);
      check({8'h0, lo}, 40'h0800);
      rd(SIZE_8, 2'h0, SWAP_PASS, lo);
      rd(SIZE_8, 2'h1, SWAP_PASS, hi);
      check({24'h0, hi[7:0], lo[7:0]}, 40'h0800);
      $display("test little-endian timer read done");
      access(1'h1, SIZE_8, 2'h2, SWAP_PASS, 32'h5a);
      ce <= 1'h0;
      cmd.req <= 1'h0;
      repeat (3) @(negedge clk);
      check({3'h0, s_write, s_be, s_wdata}, {3'h0, 1'h1, 4'h4, 32'h005a0000});
      ce <= 1'h1;
      @(negedge clk);
      $display("test clock enable freeze done");
      access(1'h1, SIZE_32, 2'h0, SWAP_32, $urandom);
      rst <= 1'h1;
      cmd.req <= 1'h0;
      @(negedge clk);
      check({3'h0, s_req, s_be, s_wdata}, 40'h0);
      check({7'h0, m_rvalid, m_rdata}, 40'h0);
      rst <= 1'h0;
      @(negedge clk);
      $display("test reset in mid run done");
      final_report();
   end
endmodule
`default_nettype wire
